// File: isa_ide_pkg.sv
// Shared constants and types for the expansion bus and drive strobe logic
package isa_ide_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned BUS_HZ = 8_000_000;
    // Half expansion clock in system clocks, rounded up so bus never runs fast
    localparam logic [3:0] HALF_CYC =
        4'((CLK_HZ + 2 * BUS_HZ - 1) / (2 * BUS_HZ));
    localparam logic [3:0] HALF_MIN = 4'h1;
    // Cycle shape in half bus clocks; 8-bit wait state base in whole bus clocks
    localparam logic [4:0] ALE_HALVES = 5'h02;
    localparam logic [4:0] END_BASE = 5'h04;
    localparam logic [1:0] WS8_BASE = 2'h2;
    // Recommended command delays and wait state codes
    localparam logic [1:0] DLY_IO_REC = 2'h1;
    localparam logic [1:0] DLY_M8_REC = 2'h1;
    localparam logic [1:0] DLY_M16_REC = 2'h0;
    localparam logic [1:0] WS8_REC = 2'h2;
    localparam logic [1:0] WS16_REC = 2'h1;
    // Drive port decodes
    localparam logic [15:0] IDE_DATA = 16'h01f0;
    localparam logic [12:0] IDE_CMD_BLK = 13'h003e;
    localparam logic [14:0] IDE_CTL_BLK = 15'h01fb;
    localparam logic [15:0] PORT_3F7 = 16'h03f7;
    localparam logic [15:0] PORT_377 = 16'h0377;
    localparam int unsigned BIT7 = 7;
    // Local drive machine recovery, in system clocks
    localparam logic [4:0] LI_REC_CYC = 5'h03;
    localparam int unsigned SYNC_W = 40;

    typedef enum logic [2:0] {
        RT_CACHE, RT_DRAM, RT_LOCAL, RT_ROM, RT_ISA
    } route_t;
    typedef enum logic [1:0] {ISA_IDLE, ISA_RUN, ISA_HOLD} isa_st_t;
    typedef enum logic [1:0] {LI_IDLE, LI_CMD, LI_REC} lide_st_t;
endpackage

// File: sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule
`default_nettype wire

// File: isa_cycle_ide.sv
// Expansion bus cycle engine and fast drive strobe generation
// What this block does
// - Claim order cache, DRAM, local, ROM, else bus
// - Unclaimed I/O to bus; block sysdata on-chip
// - Bus clock divided from input clock
// - DRAM address pins carry high data byte
// - Separate 0..3 delays: I/O, mem8, mem16
// - Delay zero at ALE fall, half clock steps
// - Delay moves command end only under zero-wait pin
// - Recommended delays 0 mem16, 1 others
// - Wait states 2..5 or 0..3, normal 4/1
// - Zero waits: command lasts one half clock
// - Honour channel ready and zero-wait pins
// - Optional one extra clock before ready
// - Byte swap and buffer steering for DMA
// - Grant floats commands, drive local master
// - Drive strobes merge bus and local strobes
// - Local machine strobes only data port
// - Buffer enable from drive-bound strobes
// - Idle selects and address lines at defaults
// - Bus cycles decode; DMA sources lines externally
// - A2 replaces byte-high on drive ports
// - Floppy input supplies bit 7 of 3F7/377
// - Doubleword data access makes two commands
// - Defaults only idle with processor owning bus
// - 3F7 read disables sysdata buffer
`timescale 1ns/1ps
`default_nettype none
module isa_cycle_ide (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // Processor cycle and claims
    input  wire logic         i_cyc_start,
    input  wire logic         i_cyc_io,
    input  wire logic         i_cyc_write,
    input  wire logic         i_cyc_16bit,
    input  wire logic         i_cyc_dword,
    input  wire logic         i_cyc_bhe_n,
    input  wire logic [15:0]  i_cyc_addr,
    input  wire logic [15:0]  i_wr_data,
    input  wire logic         i_cache_claim,
    input  wire logic         i_dram_claim,
    input  wire logic         i_local_device_claim_n,
    input  wire logic         i_boot_rom_select,
    input  wire logic         i_onchip_periph_hit,
    input  wire logic [7:0]   i_dram_addr_src,
    // Configuration
    input  wire logic         i_use_recommended,
    input  wire logic [3:0]   i_bus_half_div,
    input  wire logic [1:0]   i_dly_io,
    input  wire logic [1:0]   i_dly_mem8,
    input  wire logic [1:0]   i_dly_mem16,
    input  wire logic [1:0]   i_ws8_code,
    input  wire logic [1:0]   i_ws16_code,
    input  wire logic         i_addr_hold_en,
    input  wire logic         i_a2_subst_en,
    input  wire logic         i_fast_ide_en,
    input  wire logic [7:0]   i_drive_timing_sel,
    input  wire logic [2:0]   i_drive_num,
    input  wire logic [4:0]   i_cmd_len_a,
    input  wire logic [4:0]   i_cmd_len_b,
    // Pins from the bus side
    input  wire logic         i_chrdy,
    input  wire logic         i_zero_ws_n,
    input  wire logic         i_alt_master_grant_n,
    input  wire logic         i_ext_ior_n,
    input  wire logic         i_ext_iow_n,
    input  wire logic [15:0]  i_ext_addr,
    input  wire logic         i_ext_slave_8bit,
    input  wire logic         i_ext_local_hit,
    input  wire logic         i_floppy_bit7_input,
    input  wire logic [7:0]   i_periph_data_low,
    input  wire logic [7:0]   i_dram_addr_in,
    // Outputs
    output isa_ide_pkg::route_t o_route,
    output logic              o_cpu_ready,
    output logic [15:0]       o_rd_data,
    output logic              o_expansion_bus_clock,
    output logic              o_expansion_cycle_active,
    output logic              o_ale,
    output logic              o_ior_n,
    output logic              o_iow_n,
    output logic              o_memr_n,
    output logic              o_memw_n,
    output logic              o_cmd_oe_n,
    output logic [7:0]        o_dram_addr_bits,
    output logic              o_dram_addr_oe_n,
    output logic              o_drive_read_strobe,
    output logic              o_drive_write_strobe,
    output logic              o_drive_buffer_enable,
    output logic              o_drive_cmd_select,
    output logic              o_drive_ctrl_select,
    output logic [1:0]        o_periph_addr_low,
    output logic              o_periph_addr_oe_n,
    output logic              o_byte_high_n,
    output logic              o_sysdata_buffer_enable,
    output logic              o_sysdata_direction,
    output logic              o_byte_swap,
    output logic              o_periph_buf_dma,
    output logic              o_local_master,
    output logic              o_local_cycle_req
);
    logic        rst_m_q, rst_q, rstn;
    logic [isa_ide_pkg::SYNC_W-1:0] pin_s;
    logic        nrdy_s, zws_s, gnt_s, eior_s, eiow_s;
    logic        fbit_s, eslv8_s, elocal_s;
    logic [15:0] eaddr_s;
    logic [7:0]  dlow_s, dhigh_s;

    // Reset release through two flops
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_m_q <= 1'b0;
            rst_q   <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_q   <= rst_m_q;
        end
    end
    assign rstn = rst_q;

    // All bus-side pins pass two flops; idle-high pins go in inverted
    // so the cleared synchroniser reads idle, not a false strobe or grant
    sync2 #(.W(isa_ide_pkg::SYNC_W)) u_pins (
        .i_clk   (i_clk),
        .i_rst_n (rstn),
        .i_d     ({~i_chrdy, ~i_zero_ws_n, ~i_alt_master_grant_n,
                   ~i_ext_ior_n, ~i_ext_iow_n, i_floppy_bit7_input,
                   i_ext_slave_8bit, i_ext_local_hit, i_ext_addr,
                   i_periph_data_low, i_dram_addr_in}),
        .o_q     (pin_s)
    );
    assign {nrdy_s, zws_s, gnt_s, eior_s, eiow_s, fbit_s,
            eslv8_s, elocal_s, eaddr_s, dlow_s, dhigh_s} = pin_s;

    logic dma;
    assign dma = gnt_s;

    always_comb begin
        if (i_cache_claim)                o_route = isa_ide_pkg::RT_CACHE;
        else if (i_dram_claim)            o_route = isa_ide_pkg::RT_DRAM;
        else if (!i_local_device_claim_n) o_route = isa_ide_pkg::RT_LOCAL;
        else if (i_boot_rom_select)       o_route = isa_ide_pkg::RT_ROM;
        else                              o_route = isa_ide_pkg::RT_ISA;
    end

    // Address decodes for the processor and alternate master
    logic cyc_ide, cyc_data, cyc_3f7, fast_go, isa_go, cyc_to_isa;
    logic ext_cmd_blk, ext_ctl_blk;
    assign cyc_data = i_cyc_io && i_cyc_addr == isa_ide_pkg::IDE_DATA;
    assign cyc_ide  = i_cyc_io &&
        (i_cyc_addr[15:3] == isa_ide_pkg::IDE_CMD_BLK ||
         i_cyc_addr[15:1] == isa_ide_pkg::IDE_CTL_BLK);
    assign cyc_3f7  = i_cyc_io && !i_cyc_write &&
        (i_cyc_addr == isa_ide_pkg::PORT_3F7 ||
         i_cyc_addr == isa_ide_pkg::PORT_377);
    assign ext_cmd_blk = eaddr_s[15:3] == isa_ide_pkg::IDE_CMD_BLK;
    assign ext_ctl_blk = eaddr_s[15:1] == isa_ide_pkg::IDE_CTL_BLK;
    // I/O goes out unless the local claim takes it
    assign cyc_to_isa = i_cyc_io ? i_local_device_claim_n
                                 : (o_route == isa_ide_pkg::RT_ISA);
    // fast data port goes to the local machine, never both
    assign fast_go = i_cyc_start && !dma && cyc_to_isa && cyc_data &&
                     i_fast_ide_en;
    assign isa_go  = i_cyc_start && !dma && cyc_to_isa && !fast_go;

    logic [3:0] div_q, half_lim;
    logic       tick;
    assign half_lim = i_use_recommended ? isa_ide_pkg::HALF_CYC :
        (i_bus_half_div < isa_ide_pkg::HALF_MIN ?
         isa_ide_pkg::HALF_MIN : i_bus_half_div);
    assign tick = div_q >= half_lim - isa_ide_pkg::HALF_MIN;
    always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            div_q                 <= '0;
            o_expansion_bus_clock <= 1'b0;
        end else if (tick) begin
            div_q                 <= '0;
            o_expansion_bus_clock <= ~o_expansion_bus_clock;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    logic [1:0] dly_sel, ws8, ws16;
    logic [2:0] ws_sel;
    always_comb begin
        ws8  = i_use_recommended ? isa_ide_pkg::WS8_REC : i_ws8_code;
        ws16 = i_use_recommended ? isa_ide_pkg::WS16_REC : i_ws16_code;
        if (i_cyc_io)
            dly_sel = i_use_recommended ? isa_ide_pkg::DLY_IO_REC
                                        : i_dly_io;
        else if (i_cyc_16bit)
            dly_sel = i_use_recommended ? isa_ide_pkg::DLY_M16_REC
                                        : i_dly_mem16;
        else
            dly_sel = i_use_recommended ? isa_ide_pkg::DLY_M8_REC
                                        : i_dly_mem8;
        ws_sel = i_cyc_16bit ? {1'b0, ws16}
                             : 3'({1'b0, ws8} + {1'b0, isa_ide_pkg::WS8_BASE});
    end

    // Bus cycle state, counted in half bus clocks
    isa_ide_pkg::isa_st_t isa_q;
    logic [4:0] h_q, on_q, end_q;
    logic       wr_q, io_q, ide_q, f3_q, bhe_q, isa_rdy;
    logic [15:0] addr_q, wd_q;
    logic       at_end, stall, cmd_act, cmd_done;
    // ready low stretches, zero-wait cuts short
    assign stall   = h_q == end_q - 5'h01 && nrdy_s;
    assign cmd_act = isa_q == isa_ide_pkg::ISA_RUN && h_q >= on_q &&
                     h_q < end_q;
    assign at_end  = tick && cmd_act && !stall &&
                     (h_q == end_q - 5'h01 || zws_s);
    assign cmd_done = at_end;
    always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            isa_q  <= isa_ide_pkg::ISA_IDLE;
            h_q    <= '0;
            on_q   <= '0;
            end_q  <= '0;
            wr_q   <= 1'b0;
            io_q   <= 1'b0;
            ide_q  <= 1'b0;
            f3_q   <= 1'b0;
            bhe_q  <= 1'b1;
            addr_q <= '0;
            wd_q   <= '0;
        end else begin
            case (isa_q)
                isa_ide_pkg::ISA_IDLE: begin
                    h_q <= '0;
                    if (isa_go) begin
                        isa_q  <= isa_ide_pkg::ISA_RUN;
                        // delay counts half clocks from ALE fall
                        on_q   <= isa_ide_pkg::ALE_HALVES + 5'(dly_sel);
                        // end fixed by wait states only
                        end_q  <= isa_ide_pkg::END_BASE + 5'({ws_sel, 1'b0});
                        wr_q   <= i_cyc_write;
                        io_q   <= i_cyc_io;
                        ide_q  <= cyc_ide;
                        f3_q   <= cyc_3f7;
                        bhe_q  <= i_cyc_bhe_n;
                        addr_q <= i_cyc_addr;
                        wd_q   <= i_wr_data;
                    end
                end
                isa_ide_pkg::ISA_RUN: begin
                    if (at_end) begin
                        h_q   <= '0;
                        isa_q <= i_addr_hold_en ? isa_ide_pkg::ISA_HOLD
                                                : isa_ide_pkg::ISA_IDLE;
                    end else if (tick && !stall) begin
                        h_q <= h_q + 5'h01;
                    end
                end
                isa_ide_pkg::ISA_HOLD: isa_q <= isa_ide_pkg::ISA_IDLE;
                default: isa_q <= isa_ide_pkg::ISA_IDLE;
            endcase
        end
    end
    assign isa_rdy = (at_end && !i_addr_hold_en) ||
                     isa_q == isa_ide_pkg::ISA_HOLD;

    // Read data capture at command end
    always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            o_rd_data <= '0;
        end else if (at_end && !wr_q) begin
            // high byte comes back on DRAM address pins
            o_rd_data <= {dhigh_s, dlow_s};
            // bit 7 from the floppy input
            if (f3_q)
                o_rd_data[isa_ide_pkg::BIT7] <= fbit_s;
        end
    end

    // Local data-port machine with two phases for doublewords
    isa_ide_pkg::lide_st_t li_q;
    logic [4:0] li_cnt_q, li_len_q;
    logic       li_second_q, li_wr_q, li_rdy;
    always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            li_q        <= isa_ide_pkg::LI_IDLE;
            li_cnt_q    <= '0;
            li_len_q    <= '0;
            li_second_q <= 1'b0;
            li_wr_q     <= 1'b0;
        end else begin
            case (li_q)
                isa_ide_pkg::LI_IDLE: if (fast_go) begin
                    li_q <= isa_ide_pkg::LI_CMD;
                    // drive picks one of two timing sets
                    li_len_q <= i_drive_timing_sel[i_drive_num] ?
                                i_cmd_len_b : i_cmd_len_a;
                    li_cnt_q <= i_drive_timing_sel[i_drive_num] ?
                                i_cmd_len_b : i_cmd_len_a;
                    li_second_q <= i_cyc_dword;
                    li_wr_q     <= i_cyc_write;
                end
                isa_ide_pkg::LI_CMD: begin
                    if (li_cnt_q == '0) begin
                        li_q     <= isa_ide_pkg::LI_REC;
                        li_cnt_q <= isa_ide_pkg::LI_REC_CYC;
                    end else begin
                        li_cnt_q <= li_cnt_q - 5'h01;
                    end
                end
                isa_ide_pkg::LI_REC: begin
                    if (li_cnt_q != '0) begin
                        li_cnt_q <= li_cnt_q - 5'h01;
                    end else if (li_second_q) begin
                        li_second_q <= 1'b0;
                        li_q        <= isa_ide_pkg::LI_CMD;
                        li_cnt_q    <= li_len_q;
                    end else begin
                        li_q <= isa_ide_pkg::LI_IDLE;
                    end
                end
                default: li_q <= isa_ide_pkg::LI_IDLE;
            endcase
        end
    end
    assign li_rdy = li_q == isa_ide_pkg::LI_REC && li_cnt_q == '0 &&
                    !li_second_q;

    // Ready back to the processor
    always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) o_cpu_ready <= 1'b0;
        else       o_cpu_ready <= isa_rdy || li_rdy;
    end

    // Bus command pins, floated under grant
    logic isa_rd_cmd, isa_wr_cmd, li_rd, li_wr, ext_rd, ext_wr;
    assign isa_rd_cmd = cmd_act && !wr_q;
    assign isa_wr_cmd = cmd_act && wr_q;
    assign o_ale      = isa_q == isa_ide_pkg::ISA_RUN &&
                        h_q < isa_ide_pkg::ALE_HALVES;
    assign o_ior_n    = !(isa_rd_cmd && io_q);
    assign o_iow_n    = !(isa_wr_cmd && io_q);
    assign o_memr_n   = !(isa_rd_cmd && !io_q);
    assign o_memw_n   = !(isa_wr_cmd && !io_q);
    // float commands while the other master has the bus
    assign o_cmd_oe_n = dma;
    assign o_expansion_cycle_active = isa_q != isa_ide_pkg::ISA_IDLE;

    // time-shared DRAM address and high data byte
    assign o_dram_addr_bits = o_expansion_cycle_active ? wd_q[15:8]
                                                       : i_dram_addr_src;
    assign o_dram_addr_oe_n = o_expansion_cycle_active && !wr_q;

    assign li_rd  = li_q == isa_ide_pkg::LI_CMD && !li_wr_q;
    assign li_wr  = li_q == isa_ide_pkg::LI_CMD && li_wr_q;
    assign ext_rd = dma && eior_s;
    assign ext_wr = dma && eiow_s;
    assign o_drive_read_strobe  = !((isa_rd_cmd && io_q) || ext_rd ||
                                    li_rd);
    assign o_drive_write_strobe = !((isa_wr_cmd && io_q) || ext_wr ||
                                    li_wr);
    assign o_drive_buffer_enable = !(
        ((isa_rd_cmd || isa_wr_cmd) && io_q && ide_q) ||
        ((ext_rd || ext_wr) && (ext_cmd_blk || ext_ctl_blk)) ||
        li_q != isa_ide_pkg::LI_IDLE);

    always_comb begin
        o_periph_addr_oe_n = 1'b0;
        if (dma) begin
            o_drive_cmd_select  = !ext_cmd_blk;
            o_drive_ctrl_select = !ext_ctl_blk;
            o_periph_addr_low   = '0;
            o_byte_high_n       = 1'b1;
            o_periph_addr_oe_n  = 1'b1;
        end else if (o_expansion_cycle_active) begin
            o_drive_cmd_select  = !(io_q &&
                addr_q[15:3] == isa_ide_pkg::IDE_CMD_BLK);
            o_drive_ctrl_select = !(io_q &&
                addr_q[15:1] == isa_ide_pkg::IDE_CTL_BLK);
            o_periph_addr_low   = addr_q[1:0];
            o_byte_high_n       = (i_a2_subst_en && ide_q) ? addr_q[2]
                                                           : bhe_q;
        end else begin
            // defaults only while idle and processor owns bus
            o_drive_cmd_select  = 1'b0;
            o_drive_ctrl_select = 1'b1;
            o_periph_addr_low   = '0;
            o_byte_high_n       = 1'b0;
        end
    end

    assign o_sysdata_buffer_enable = !(o_expansion_cycle_active &&
        !(f3_q || (io_q && !wr_q && i_onchip_periph_hit)));
    assign o_sysdata_direction = !(o_expansion_cycle_active && !wr_q &&
                                   !ide_q);

    // byte swap and buffer steering for DMA
    assign o_byte_swap      = dma && eslv8_s && eaddr_s[0];
    assign o_periph_buf_dma = dma && (ext_cmd_blk || ext_ctl_blk);

    // local master request on external command start
    logic ext_cmd_q;
    always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            ext_cmd_q         <= 1'b0;
            o_local_cycle_req <= 1'b0;
        end else begin
            ext_cmd_q         <= ext_rd || ext_wr;
            o_local_cycle_req <= (ext_rd || ext_wr) && !ext_cmd_q &&
                                 elocal_s;
        end
    end
    assign o_local_master = dma;

    // Checks
    cmd_float_a: assert property (@(posedge i_clk) disable iff (!rstn)
        dma |-> o_cmd_oe_n && o_periph_addr_oe_n && o_byte_high_n)
        else $error("commands not floated");
    idle_default_a: assert property (@(posedge i_clk) disable iff (!rstn)
        (!dma && !o_expansion_cycle_active) |-> (o_drive_ctrl_select &&
        !o_drive_cmd_select && o_periph_addr_low == 2'h0))
        else $error("idle defaults wrong");
    strobe_merge_a: assert property (@(posedge i_clk) disable iff (!rstn)
        (!o_ior_n || li_rd) |-> !o_drive_read_strobe)
        else $error("read strobe not merged");
    one_source_a: assert property (@(posedge i_clk) disable iff (!rstn)
        !(li_q != isa_ide_pkg::LI_IDLE && o_expansion_cycle_active))
        else $error("two strobe sources");
    addr_hold_a: assert property (@(posedge i_clk) disable iff (!rstn)
        (cmd_done && i_addr_hold_en) |=> !o_cpu_ready ##1 o_cpu_ready)
        else $error("address hold ready timing");
    floppy_bit_a: assert property (@(posedge i_clk) disable iff (!rstn)
        (at_end && !wr_q && f3_q) |=> o_rd_data[7] == $past(fbit_s))
        else $error("bit 7 not from floppy");
    dword_two_a: assert property (@(posedge i_clk) disable iff (!rstn)
        (li_q == isa_ide_pkg::LI_REC && li_second_q) |->
        ##[1:8] li_q == isa_ide_pkg::LI_CMD)
        else $error("second command missing");
    sysdata_off_a: assert property (@(posedge i_clk) disable iff (!rstn)
        (o_expansion_cycle_active && f3_q) |-> o_sysdata_buffer_enable)
        else $error("sysdata on for 3F7");
    a2_subst_a: assert property (@(posedge i_clk) disable iff (!rstn)
        (!dma && o_expansion_cycle_active && ide_q && i_a2_subst_en) |->
        o_byte_high_n == addr_q[2]) else $error("A2 not substituted");
    claim_skip_a: assert property (@(posedge i_clk) disable iff (!rstn)
        (i_cyc_start && !i_cyc_io && o_route != isa_ide_pkg::RT_ISA &&
        !o_expansion_cycle_active) |=> !o_expansion_cycle_active)
        else $error("claimed cycle went out");
endmodule
`default_nettype wire

// File: isa_slave_model.sv
// Expansion bus slave answering read commands
`timescale 1ns/1ps
`default_nettype none
module isa_slave_model (
    input  wire logic       i_clk,
    input  wire logic       i_ior_n,
    output logic      [7:0] o_data
);
    initial o_data = 8'h00;
    // drive bits 0..6 only while read is active
    always @(posedge i_clk) begin
        o_data <= i_ior_n ? ~o_data : 8'h7f; // Released bus toggles
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for bus cycle and drive strobe block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clk, i_rst_n, i_cyc_start, i_cyc_io, i_cyc_write, i_cyc_16bit;
    logic i_cyc_dword, i_cyc_bhe_n, i_cache_claim, i_dram_claim, i_chrdy;
    logic i_local_device_claim_n, i_boot_rom_select, i_onchip_periph_hit;
    logic i_use_recommended, i_addr_hold_en, i_a2_subst_en, i_fast_ide_en;
    logic i_zero_ws_n, i_alt_master_grant_n, i_ext_ior_n, i_ext_iow_n;
    logic i_ext_slave_8bit, i_ext_local_hit, i_floppy_bit7_input, s;
    logic [15:0] i_cyc_addr, i_wr_data, i_ext_addr, o_rd_data;
    logic [7:0]  i_dram_addr_src, i_drive_timing_sel, i_periph_data_low;
    logic [7:0]  i_dram_addr_in, o_dram_addr_bits;
    logic [4:0]  i_cmd_len_a, i_cmd_len_b;
    logic [3:0]  i_bus_half_div;
    logic [2:0]  i_drive_num;
    logic [1:0]  i_dly_io, i_dly_mem8, i_dly_mem16, i_ws8_code, i_ws16_code;
    logic [1:0]  o_periph_addr_low;
    isa_ide_pkg::route_t o_route;
    logic o_cpu_ready, o_expansion_bus_clock, o_expansion_cycle_active, o_ale;
    logic o_ior_n, o_iow_n, o_memr_n, o_memw_n, o_cmd_oe_n, o_dram_addr_oe_n;
    logic o_drive_read_strobe, o_drive_write_strobe, o_drive_buffer_enable;
    logic o_drive_cmd_select, o_drive_ctrl_select, o_periph_addr_oe_n;
    logic o_byte_high_n, o_sysdata_buffer_enable, o_sysdata_direction;
    logic o_byte_swap, o_periph_buf_dma, o_local_master, o_local_cycle_req;
    int   mismatches = 0, n_compared = 0, cyc = 0, n0, n;
    logic [3:0] cl [5] = '{4'hd, 4'h5, 4'h1, 4'h3, 4'h2};

    isa_cycle_ide dut_u (.*);
    isa_slave_model slave_u (.i_clk(i_clk), .i_ior_n(o_ior_n),
                             .o_data(i_periph_data_low));

    always #12.5 i_clk = ~i_clk;

    // Hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, exp, input string m);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    // One processor cycle, counting clocks until ready
    task automatic run(output int cnt);
        // Start on a fixed bus clock phase so counts repeat
        @(posedge o_expansion_bus_clock);
        #1 i_cyc_start = 1;
        @(posedge i_clk);
        #1 i_cyc_start = 0;
        cnt = 1;
        s = 1;
        while (o_cpu_ready !== 1'b1 && cnt < 300) begin
            @(posedge i_clk);
            #1 cnt++;
            s &= o_drive_read_strobe;
        end
    endtask

    initial begin
        {i_clk, i_rst_n, i_cyc_start, i_cyc_write, i_cyc_dword, i_cache_claim,
         i_dram_claim, i_boot_rom_select, i_onchip_periph_hit, i_a2_subst_en,
         i_use_recommended, i_addr_hold_en, i_ext_slave_8bit,
         i_ext_local_hit} = '0;
        {i_cyc_io, i_cyc_16bit, i_cyc_bhe_n, i_local_device_claim_n, i_chrdy,
         i_zero_ws_n, i_alt_master_grant_n, i_ext_ior_n, i_ext_iow_n,
         i_fast_ide_en, i_floppy_bit7_input} = '1;
        {i_wr_data, i_ext_addr, i_dram_addr_src, i_drive_timing_sel,
         i_dram_addr_in, i_cmd_len_a, i_cmd_len_b, i_drive_num, i_dly_io,
         i_dly_mem8, i_dly_mem16, i_ws8_code, i_ws16_code} = '0;
        i_cyc_addr = 16'h03f7;
        i_bus_half_div = 4'h4;
        repeat (5) @(posedge i_clk);
        #1 i_rst_n = 1;
        repeat (6) @(posedge i_clk);
        #1 chk(16'({o_drive_cmd_select, o_drive_ctrl_select,
                o_periph_addr_low, o_byte_high_n}), 16'h0008,
                "idle defaults");
        // Claimed memory cycles start but never reach the bus
        for (int i = 0; i < 5; i++) begin
            @(posedge i_clk);
            #1 {i_cyc_io, i_cyc_start, i_cache_claim, i_dram_claim,
                i_local_device_claim_n, i_boot_rom_select} =
                {i == 4, i < 4, cl[i]};
            @(negedge i_clk);
            chk(16'({o_expansion_cycle_active, o_route}), 16'(i),
                "claim");
        end
        $display("claim test done");
        run(n0);
        chk(16'(o_rd_data[7:0]), 16'h00ff, "floppy bit");
        chk(16'(s), 16'h0000, "strobe merge");
        i_ws16_code = 2'h1;
        run(n);
        chk(16'(n), 16'(n0 + 8), "wait state");
        i_ws16_code = 2'h0;
        i_dly_io = 2'h1;
        run(n);
        chk(16'(n), 16'(n0), "delay keeps end");
        i_addr_hold_en = 1;
        run(n);
        chk(16'(n), 16'(n0 + 1), "address hold");
        $display("bus cycle test done");
        // Data port doubleword through the local machine
        i_cyc_addr = 16'h01f0;
        i_cyc_dword = 1;
        run(n);
        chk(16'(n), 16'h000b, "two local commands");
        chk(16'(s), 16'h0000, "local strobe");
        // Alternate master reads a drive port, odd byte, 8-bit slave
        {i_alt_master_grant_n, i_ext_ior_n} = '0;
        i_ext_addr = 16'h01f1;
        i_ext_slave_8bit = 1;
        repeat (3) @(posedge i_clk);
        #1 chk(16'({o_cmd_oe_n, o_local_master, o_periph_addr_oe_n}),
               16'h0007, "grant floats commands");
        chk(16'({o_drive_read_strobe, o_drive_buffer_enable,
            o_drive_cmd_select}), 16'h0000, "external strobe");
        chk(16'(o_byte_swap), 16'h0001, "byte swap");
        $display("drive and master test done");
        complete_run();
    end
endmodule
`default_nettype wire
